//--- core/ritmr_pkg.sv
// Constants, register map and field layout of the 8-bit reload/interval timer.
// Assumes a single system clock domain; byte address of a register is index * 4.
package ritmr_pkg;

  // Bus widths
  localparam int              RITMR_AW        = 20;
  localparam int              RITMR_DW        = 32;

  // Register indexes; byte address is four times the index
  localparam logic [15:0]     RITMR_MODE_IDX  = 16'hFFB2;
  localparam logic [15:0]     RITMR_COUNT_IDX = 16'hFFB3;
  localparam logic [15:0]     RITMR_IRQ_IDX   = 16'hFFC0;
  localparam logic [15:0]     RITMR_IEN_IDX   = 16'hFFC1;
  localparam logic [15:0]     RITMR_EDGE_IDX  = 16'hFFC2;

  // Mode register layout and reset values
  localparam int              RITMR_RELOAD_BIT = 7;
  localparam logic [3:0]      RITMR_RSVD_ONES  = 4'hF;
  localparam logic [7:0]      RITMR_MODE_RST   = 8'h78;
  localparam logic [7:0]      RITMR_BYTE_RST   = 8'h00;
  localparam logic [7:0]      RITMR_COUNT_TOP  = 8'hFF;
  localparam logic [2:0]      RITMR_SEL_EXT    = 3'h7;

  // Interrupt and edge bits (bit 0 of their registers)
  localparam int              RITMR_OVF_BIT   = 0;
  localparam int              RITMR_EDGE_BIT  = 0;

  // Prescaler: taps as log2 of the division, in clock select code order
  localparam int              RITMR_PSC_W     = 13;
  localparam int              RITMR_NTAPS     = 7;
  localparam int              RITMR_TAP_LOG2 [0:6] = '{13, 11, 9, 8, 6, 4, 2};

  // AXI responses
  localparam logic [1:0]      RITMR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RITMR_RESP_SLVERR = 2'h2;

  // True when a byte address selects the register at the given index
  function automatic logic ritmr_hit(input logic [RITMR_AW-1:0] addr,
                                     input logic [15:0] idx);
    ritmr_hit = (addr[RITMR_AW-1:2] == {2'b00, idx});
  endfunction

endpackage

//--- core/ritmr_prescaler.sv
// Free-running system clock divider giving one-cycle ticks at seven tap rates.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ritmr_prescaler
  import ritmr_pkg::*;
(
  input  wire logic                   aclk,    // System clock
  input  wire logic                   aresetn, // Synchronous reset, active low
  output logic      [ritmr_pkg::RITMR_NTAPS-1:0] tick // One pulse per tap period
);

  import ritmr_pkg::*;

  logic [RITMR_PSC_W-1:0] div_q; // Divider count

  // Divider runs from reset on every edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // Each tap pulses when its low bits are all ones
  generate
    for (genvar i = 0; i < RITMR_NTAPS; i++)
    begin : g_tap
      assign tick[i] = &div_q[RITMR_TAP_LOG2[i]-1:0];
    end
  endgenerate

endmodule

//--- core/ritmr_event_sync.sv
// Synchroniser and edge detector for the external event pin.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/1ps
module ritmr_event_sync
(
  input  wire logic aclk,       // System clock
  input  wire logic aresetn,    // Synchronous reset, active low
  input  wire logic pin,        // Raw event pin
  input  wire logic rise_sel,   // 1 counts rising edges, 0 falling
  output logic      evt         // One-cycle pulse per chosen edge
);

  logic meta_q;  // First stage, read only by the second
  logic sync_q;  // Second stage
  logic prev_q;  // Delayed copy for edge detection

  // Two-stage synchroniser then a history flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Single pulse on the chosen edge only
  assign evt = rise_sel ? (sync_q & ~prev_q) : (~sync_q & prev_q);

endmodule

//--- core/ritmr_top.sv
// 8-bit up-counting timer with interval and auto-reload modes, AXI4-Lite slave.
// Assumes a single AXI master, event pin that may change at any time (synchronised inside), one system clock.
// Operation
// - Mode bit 7 picks interval when 0, auto-reload when 1.
// - Mode bits 6 to 3 read as ones and ignore writes.
// - Clock codes 0 to 6 pick divide by 8192,2048,512,256,64,16,4.
// - Clock code 7 counts edges of the external event pin.
// - Edge select bit decides rising or falling event edges.
// - Counter increments by one per selected pulse; no direct software write.
// - Counter is readable at any time without stopping the count.
// - Wrap from FF sets the overflow request flag.
// - Counter and load register share one address: read count, write load.
// - Load register is 8-bit write-only, holds preset and reload value.
// - Writing the load register also presets the counter immediately.
// - Auto-reload mode reloads the load value on each overflow.
// - Reset gives mode 78, counter 00, load register 00.
// - Interrupt requested only when overflow enable is set; flag set always.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ritmr_top
  import ritmr_pkg::*;
(
  input  wire logic                        aclk,            // System clock, 25 MHz
  input  wire logic                        aresetn,         // Synchronous reset, active low
  input  wire logic [ritmr_pkg::RITMR_AW-1:0] s_axi_awaddr, // Write address
  input  wire logic                        s_axi_awvalid,   // Write address valid
  output logic                             s_axi_awready,   // Write address ready
  input  wire logic [31:0]                 s_axi_wdata,     // Write data
  input  wire logic [3:0]                  s_axi_wstrb,     // Write byte enables
  input  wire logic                        s_axi_wvalid,    // Write data valid
  output logic                             s_axi_wready,    // Write data ready
  output logic [1:0]                       s_axi_bresp,     // Write response
  output logic                             s_axi_bvalid,    // Write response valid
  input  wire logic                        s_axi_bready,    // Write response ready
  input  wire logic [ritmr_pkg::RITMR_AW-1:0] s_axi_araddr, // Read address
  input  wire logic                        s_axi_arvalid,   // Read address valid
  output logic                             s_axi_arready,   // Read address ready
  output logic [31:0]                      s_axi_rdata,     // Read data
  output logic [1:0]                       s_axi_rresp,     // Read response
  output logic                             s_axi_rvalid,    // Read data valid
  input  wire logic                        s_axi_rready,    // Read data ready
  input  wire logic                        event_input_pin, // External event input
  output logic                             irq              // Level interrupt, active high
);

  import ritmr_pkg::*;

  // Software-visible state
  logic                   reload_select_q;     // Mode bit 7
  logic [2:0]             clock_source_sel_q;  // Mode bits 2..0
  logic [7:0]             up_count_q;          // Counter
  logic [7:0]             reload_value_q;      // Load register
  logic                   overflow_request_q;  // Sticky overflow flag
  logic                   overflow_irq_en_q;   // Overflow interrupt enable
  logic                   event_edge_sel_q;    // 1 rising, 0 falling
  logic                   irq_q;               // Registered interrupt

  // Bus slave state
  logic                   aw_have_q;
  logic [RITMR_AW-1:0]    aw_addr_q;
  logic                   w_have_q;
  logic [7:0]             w_byte_q;
  logic                   w_lane0_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   rvalid_q;
  logic [31:0]            rdata_q;
  logic [1:0]             rresp_q;

  // Internal strobes
  logic [RITMR_NTAPS-1:0] tap_tick;
  logic                   evt_pulse;
  logic                   count_tick;
  logic                   overflow;
  logic                   do_wr;
  logic                   wr_en;
  logic                   wr_mapped;
  logic                   wr_load;
  logic                   ar_take;
  logic [7:0]             mode_rd;

  // Divider taps
  ritmr_prescaler ritmr_prescaler_i
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tap_tick)
  );

  // Event pin conditioning
  ritmr_event_sync ritmr_event_sync_i
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin      (event_input_pin),
    .rise_sel (event_edge_sel_q),
    .evt      (evt_pulse)
  );

  // Count source selection
  assign count_tick = (clock_source_sel_q == RITMR_SEL_EXT) ? evt_pulse
                                                            : tap_tick[clock_source_sel_q];
  assign overflow   = count_tick && (up_count_q == RITMR_COUNT_TOP);

  // Mode register read view, reserved bits forced to ones
  assign mode_rd = {reload_select_q, RITMR_RSVD_ONES, clock_source_sel_q};

  // Write channel handshakes; both halves are taken in either order
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign do_wr         = aw_have_q && w_have_q && !bvalid_q;
  assign wr_mapped     = ritmr_hit(aw_addr_q, RITMR_MODE_IDX)
                      || ritmr_hit(aw_addr_q, RITMR_COUNT_IDX)
                      || ritmr_hit(aw_addr_q, RITMR_IRQ_IDX)
                      || ritmr_hit(aw_addr_q, RITMR_IEN_IDX)
                      || ritmr_hit(aw_addr_q, RITMR_EDGE_IDX);
  assign wr_en         = do_wr && w_lane0_q && wr_mapped;
  assign wr_load       = wr_en && ritmr_hit(aw_addr_q, RITMR_COUNT_IDX);

  // Write address and data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_byte_q  <= RITMR_BYTE_RST;
      w_lane0_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q  <= 1'b1;
        w_byte_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      else if (do_wr)
        w_have_q <= 1'b0;
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RITMR_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? RITMR_RESP_OKAY : RITMR_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Mode register fields; reserved bits are not stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reload_select_q    <= RITMR_MODE_RST[RITMR_RELOAD_BIT];
      clock_source_sel_q <= RITMR_MODE_RST[2:0];
    end
    else if (wr_en && ritmr_hit(aw_addr_q, RITMR_MODE_IDX))
    begin
      reload_select_q    <= w_byte_q[RITMR_RELOAD_BIT];
      clock_source_sel_q <= w_byte_q[2:0];
    end
  end

  // Load register, write-only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reload_value_q <= RITMR_BYTE_RST;
    else if (wr_load)
      reload_value_q <= w_byte_q;
  end

  // Counter: load write presets, overflow wraps or reloads, else steps
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      up_count_q <= RITMR_BYTE_RST;
    else if (wr_load)
      up_count_q <= w_byte_q;
    else if (overflow)
      up_count_q <= reload_select_q ? reload_value_q
                                    : RITMR_BYTE_RST;
    else if (count_tick)
      up_count_q <= up_count_q + 8'h01;
  end

  // Overflow flag: set wins over a write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      overflow_request_q <= 1'b0;
    else if (overflow)
      overflow_request_q <= 1'b1;
    else if (wr_en && ritmr_hit(aw_addr_q, RITMR_IRQ_IDX) && w_byte_q[RITMR_OVF_BIT])
      overflow_request_q <= 1'b0;
  end

  // Enable and edge select registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_irq_en_q <= 1'b0;
      event_edge_sel_q  <= 1'b0;
    end
    else
    begin
      if (wr_en && ritmr_hit(aw_addr_q, RITMR_IEN_IDX))
        overflow_irq_en_q <= w_byte_q[RITMR_OVF_BIT];
      if (wr_en && ritmr_hit(aw_addr_q, RITMR_EDGE_IDX))
        event_edge_sel_q <= w_byte_q[RITMR_EDGE_BIT];
    end
  end

  // Interrupt level gated by the enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else
      irq_q <= overflow_request_q && overflow_irq_en_q;
  end

  assign irq = irq_q;

  // Read channel: one read in flight, data registered
  assign ar_take       = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RITMR_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= RITMR_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      if (ritmr_hit(s_axi_araddr, RITMR_MODE_IDX))
        rdata_q[7:0] <= mode_rd;
      else if (ritmr_hit(s_axi_araddr, RITMR_COUNT_IDX))
        rdata_q[7:0] <= up_count_q;
      else if (ritmr_hit(s_axi_araddr, RITMR_IRQ_IDX))
        rdata_q[RITMR_OVF_BIT] <= overflow_request_q;
      else if (ritmr_hit(s_axi_araddr, RITMR_IEN_IDX))
        rdata_q[RITMR_OVF_BIT] <= overflow_irq_en_q;
      else if (ritmr_hit(s_axi_araddr, RITMR_EDGE_IDX))
        rdata_q[RITMR_EDGE_BIT] <= event_edge_sel_q;
      else
        rresp_q <= RITMR_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // Helper: remembers that the answer in flight is a mode register read
  logic rd_mode_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_mode_q <= 1'b0;
    else if (ar_take)
      rd_mode_q <= ritmr_hit(s_axi_araddr, RITMR_MODE_IDX);
  end

  // Checks on the counter, flag, interrupt, event and mode read paths
  reload_on_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow && reload_select_q && !wr_load |=> up_count_q == $past(reload_value_q))
    else $error("auto-reload did not load the reload value");

  interval_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow && !reload_select_q && !wr_load |=> up_count_q == 8'h00)
    else $error("interval overflow did not return to zero");

  count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    count_tick && !overflow && !wr_load |=> up_count_q == $past(up_count_q) + 8'h01)
    else $error("counter did not step by one");

  count_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !count_tick && !wr_load |=> $stable(up_count_q))
    else $error("counter moved without a tick");

  preset_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_load |=> up_count_q == $past(w_byte_q) && reload_value_q == $past(w_byte_q))
    else $error("load write did not preset counter");

  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow |=> overflow_request_q)
    else $error("overflow did not set the request flag");

  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow && !overflow_irq_en_q |=> !irq && overflow_request_q)
    else $error("interrupt raised while disabled");

  mode_rsvd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && rd_mode_q |-> s_axi_rdata[6:3] == 4'hF)
    else $error("reserved mode bits not read as ones");

  event_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
    evt_pulse |=> !evt_pulse)
    else $error("event edge counted more than once");

  ext_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clock_source_sel_q == RITMR_SEL_EXT && evt_pulse && !wr_load
      && up_count_q != RITMR_COUNT_TOP |=> up_count_q == $past(up_count_q) + 8'h01)
    else $error("event did not step the counter");

  reset_vals_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> mode_rd == 8'h78 && up_count_q == 8'h00 && reload_value_q == 8'h00)
    else $error("reset values wrong");

  // Main scenarios
  ovf_reload_c: cover property (@(posedge aclk) disable iff (!aresetn)
    overflow && reload_select_q);
  ovf_interval_c: cover property (@(posedge aclk) disable iff (!aresetn)
    overflow && !reload_select_q);
  ext_count_c: cover property (@(posedge aclk) disable iff (!aresetn)
    evt_pulse && clock_source_sel_q == 3'h7);
  irq_raise_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq));

endmodule

//--- bench/ritmr_tb.sv
// Self-checking bench for the 8-bit reload/interval timer: AXI4-Lite tasks and directed tests.
// Assumes the design's own assertions guard the ports; one 25 MHz clock, no partner model.
`timescale 1ns/1ps
module ritmr_tb;
  import ritmr_pkg::*;

  logic                aclk;          // System clock
  logic                aresetn;       // Synchronous reset, active low
  logic [RITMR_AW-1:0] awaddr;        // Write address
  logic                awvalid;       // Write address valid
  logic                awready;       // Write address ready
  logic [31:0]         wdata;         // Write data
  logic [3:0]          wstrb;         // Write byte enables
  logic                wvalid;        // Write data valid
  logic                wready;        // Write data ready
  logic [1:0]          bresp;         // Write response
  logic                bvalid;        // Write response valid
  logic                bready;        // Write response ready
  logic [RITMR_AW-1:0] araddr;        // Read address
  logic                arvalid;       // Read address valid
  logic                arready;       // Read address ready
  logic [31:0]         rdata;         // Read data
  logic [1:0]          rresp;         // Read response
  logic                rvalid;        // Read data valid
  logic                rready;        // Read data ready
  logic                pin;           // External event pin
  logic                irq;           // Interrupt output
  logic [31:0]         rd_v;          // Last read value
  int                  fail_count;    // Mismatches
  int                  n_tests;       // Comparisons
  int                  divs [0:6] = '{8192, 2048, 512, 256, 64, 16, 4};

  ritmr_top ritmr_top_i (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .s_axi_awaddr    (awaddr),
    .s_axi_awvalid   (awvalid),
    .s_axi_awready   (awready),
    .s_axi_wdata     (wdata),
    .s_axi_wstrb     (wstrb),
    .s_axi_wvalid    (wvalid),
    .s_axi_wready    (wready),
    .s_axi_bresp     (bresp),
    .s_axi_bvalid    (bvalid),
    .s_axi_bready    (bready),
    .s_axi_araddr    (araddr),
    .s_axi_arvalid   (arvalid),
    .s_axi_arready   (arready),
    .s_axi_rdata     (rdata),
    .s_axi_rresp     (rresp),
    .s_axi_rvalid    (rvalid),
    .s_axi_rready    (rready),
    .event_input_pin (pin),
    .irq             (irq)
  );

  // Clock generator, 40 ns period
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then stops
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Exact compare with case equality
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Range compare for values that move with the free-running divider
  task automatic check_rng(input string what, input logic [31:0] lo, input logic [31:0] hi,
                           input logic [31:0] got);
    n_tests++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      $display("unexpected %s: expected %h to %h seen %h", what, lo, hi, got);
      fail_count++;
    end
  endtask

  // AXI4-Lite write of one byte to a register index, response checked
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] exp);
    int n;
    @(posedge aclk);
    awaddr  <= RITMR_AW'({idx, 2'b00});
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        check("bresp", {30'h0, exp}, {30'h0, bresp});
        break;
      end
    end
    if (n == 50)
    begin
      $display("unexpected bvalid: expected 1 seen 0");
      fail_count++;
      finish_test();
    end
  endtask

  // AXI4-Lite read of a register index, response checked, data to rd_v
  task automatic rd(input logic [15:0] idx, input logic [1:0] exp);
    int n;
    @(posedge aclk);
    araddr  <= RITMR_AW'({idx, 2'b00});
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        rd_v = rdata;
        check("rresp", {30'h0, exp}, {30'h0, rresp});
        break;
      end
    end
    if (n == 50)
    begin
      $display("unexpected rvalid: expected 1 seen 0");
      fail_count++;
      finish_test();
    end
  endtask

  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, pin} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    fail_count = 0;
    n_tests = 0;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;

    // Reset values
    rd(RITMR_MODE_IDX, RITMR_RESP_OKAY); check("mode", 32'h78, rd_v);
    rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check("count", 32'h00, rd_v);
    rd(RITMR_IRQ_IDX, RITMR_RESP_OKAY); check("flag", 32'h00, rd_v);
    check("irq", 32'h0, {31'h0, irq});
    $display("test reset done");

    // Mode layout, reserved bits and unmapped place
    wr(RITMR_MODE_IDX, 8'h80, RITMR_RESP_OKAY);
    rd(RITMR_MODE_IDX, RITMR_RESP_OKAY); check("mode", 32'hF8, rd_v);
    wr(RITMR_MODE_IDX, 8'h07, RITMR_RESP_OKAY);
    rd(RITMR_MODE_IDX, RITMR_RESP_OKAY); check("mode", 32'h7F, rd_v);
    // Byte lane 0 disabled: the write must leave the mode untouched
    wstrb <= 4'hE;
    wr(RITMR_MODE_IDX, 8'h80, RITMR_RESP_OKAY);
    wstrb <= 4'hF;
    rd(RITMR_MODE_IDX, RITMR_RESP_OKAY); check("mode lane off", 32'h7F, rd_v);
    wr(16'hFFB4, 8'h55, RITMR_RESP_SLVERR);
    rd(16'hFFB4, RITMR_RESP_SLVERR); check("unmapped", 32'h0, rd_v);
    $display("test mode done");

    // Every internal clock code: about three ticks in three periods
    for (int c = 0; c < 7; c++)
    begin
      wr(RITMR_MODE_IDX, 8'(c), RITMR_RESP_OKAY);
      wr(RITMR_COUNT_IDX, 8'h00, RITMR_RESP_OKAY);
      repeat (3 * divs[c] - 4) @(posedge aclk);
      rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check_rng("tick count", 2, 4, rd_v);
    end
    $display("test clock codes done");

    // Interval overflow, flag, enable and clear
    wr(RITMR_IRQ_IDX, 8'h01, RITMR_RESP_OKAY);
    wr(RITMR_COUNT_IDX, 8'hF0, RITMR_RESP_OKAY);
    rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check_rng("preset", 32'hF0, 32'hF3, rd_v);
    repeat (80) @(posedge aclk);
    rd(RITMR_IRQ_IDX, RITMR_RESP_OKAY); check("flag", 32'h01, rd_v);
    check("irq masked", 32'h0, {31'h0, irq});
    rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check_rng("wrap", 32'h00, 32'h10, rd_v);
    wr(RITMR_IEN_IDX, 8'h01, RITMR_RESP_OKAY);
    rd(RITMR_IEN_IDX, RITMR_RESP_OKAY); check("enable", 32'h01, rd_v);
    repeat (2) @(posedge aclk);
    check("irq", 32'h1, {31'h0, irq});
    wr(RITMR_IRQ_IDX, 8'h01, RITMR_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    rd(RITMR_IRQ_IDX, RITMR_RESP_OKAY); check("flag", 32'h00, rd_v);
    $display("test overflow done");

    // Auto-reload keeps the count in the reload window
    wr(RITMR_MODE_IDX, 8'h86, RITMR_RESP_OKAY);
    wr(RITMR_COUNT_IDX, 8'hFC, RITMR_RESP_OKAY);
    repeat (4)
    begin
      repeat (37) @(posedge aclk);
      rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check_rng("reload", 32'hFC, 32'hFF, rd_v);
    end
    wr(RITMR_COUNT_IDX, 8'hFF, RITMR_RESP_OKAY);
    repeat (9) @(posedge aclk);
    rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check("reload one", 32'hFF, rd_v);
    rd(RITMR_IRQ_IDX, RITMR_RESP_OKAY); check("flag", 32'h01, rd_v);
    $display("test reload done");

    // External events: falling then rising edges, one count per edge
    wr(RITMR_MODE_IDX, 8'h07, RITMR_RESP_OKAY);
    for (int e = 0; e < 2; e++)
    begin
      wr(RITMR_EDGE_IDX, 8'(e), RITMR_RESP_OKAY);
      rd(RITMR_EDGE_IDX, RITMR_RESP_OKAY); check("edge", 32'(e), rd_v);
      wr(RITMR_COUNT_IDX, 8'h00, RITMR_RESP_OKAY);
      pin <= 1'b1;
      repeat (8) @(posedge aclk);
      rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check("rise", 32'(e), rd_v);
      pin <= 1'b0;
      repeat (8) @(posedge aclk);
      rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check("fall", 32'h01, rd_v);
    end
    repeat (3)
    begin
      pin <= 1'b1;
      repeat (6) @(posedge aclk);
      pin <= 1'b0;
      repeat (6) @(posedge aclk);
    end
    rd(RITMR_COUNT_IDX, RITMR_RESP_OKAY); check("events", 32'h04, rd_v);
    $display("test events done");

    finish_test();
  end
endmodule
